/* area_bus_config.sv */
// Purpose: Area bus width, access length and wait-state configuration
// Assumes: APB slave on clk; mode pins come from outside and are synchronised
// Notes:   Width bits load from the synced mode at the first edge after reset
// Operation
// - Width bit 0 means 16-bit, 1 means 8-bit
// - Eight width bits, bit n for area n
// - State bit 0 two states, 1 three states
// - Wait mode field selects programmable, none, pin, auto
// - Wait count field inserts zero to three waits
// - Enable bit 0 disables wait control, pin mode 0
// - Eight wait enable bits, reset to one
// - Mode report low three bits follow mode pins, top five bits fixed, read only
// - Mode codes 001 to 100 for modes 1-4
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module area_bus_config
(
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  input  wire logic [2:0]                   mode_pins,
  input  wire logic                         wait_pin,
  input  wire area_bus_pkg::area_req_type   access_req,
  output area_bus_pkg::area_shape_type      access_shape,
  output logic                              access_busy,
  output logic                              access_done,
  output logic [7:0]                        area_narrow,
  output logic [7:0]                        area_long
);

  logic [2:0] mode_meta_q;
  logic [2:0] mode_sync_q;
  logic [2:0] mode_q;
  logic       boot_q;
  logic [7:0] width_q;
  logic [7:0] states_q;
  logic [7:0] wait_en_q;
  logic [1:0] wait_mode_q;
  logic [1:0] wait_count_q;
  logic [7:0] width_d;
  logic [7:0] states_d;
  logic [7:0] wait_en_d;
  logic [1:0] wait_mode_d;
  logic [1:0] wait_count_d;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        wait_meta_q;
  logic        mode_sync_pin_wait_q;

  logic        wr_fire;
  logic        rd_fire;
  logic        hit_width;
  logic        hit_states;
  logic        hit_wctl;
  logic        hit_wen;
  logic        hit_mode;
  logic        mapped;
  logic        wr_ok;
  logic [7:0]  wctl_view;
  logic [7:0]  mode_view;
  logic [7:0]  rd_byte;
  logic        boot_narrow;
  logic [2:0]  area;
  logic        area_wen;
  logic        area_long_bit;
  logic [1:0]  eff_waits;
  area_bus_pkg::wait_mode_type eff_mode;
  area_bus_pkg::area_shape_type shape;

  function automatic logic [7:0] merge_byte(input logic [7:0] cur, input logic [31:0] wd,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? wd[7:0] : cur;
  endfunction

  // Bus decode
  assign wr_fire    = psel && penable && pwrite;
  assign rd_fire    = psel && penable && !pwrite;
  assign hit_width  = (paddr == area_bus_pkg::ADDR_BUS_WIDTH);
  assign hit_states = (paddr == area_bus_pkg::ADDR_ACCESS_STATES);
  assign hit_wctl   = (paddr == area_bus_pkg::ADDR_WAIT_CONTROL);
  assign hit_wen    = (paddr == area_bus_pkg::ADDR_WAIT_ENABLE);
  assign hit_mode   = (paddr == area_bus_pkg::ADDR_MODE_REPORT);
  assign mapped     = hit_width || hit_states || hit_wctl || hit_wen || hit_mode;
  assign wr_ok      = wr_fire && !boot_q;
  assign pready     = 1'b1;
  assign prdata     = prdata_q;
  assign pslverr    = pslverr_q;

  // Mode report: fixed top bits, code from pins
  assign mode_view = {area_bus_pkg::MODE_RPT_TOP, mode_q};
  assign wctl_view = {area_bus_pkg::WAIT_CTRL_TOP, wait_mode_q, wait_count_q};

  assign rd_byte = hit_width  ? width_q :
                   hit_states ? states_q :
                   hit_wctl   ? wctl_view :
                   hit_wen    ? wait_en_q :
                   hit_mode   ? mode_view : 8'h00;

  // Modes 1 and 3 boot narrow, modes 2 and 4 wide
  assign boot_narrow = (mode_q == area_bus_pkg::MODE_1) ||
                       (mode_q == area_bus_pkg::MODE_3);

  assign width_d   = hit_width ? merge_byte(width_q, pwdata, pstrb) : width_q;
  assign states_d  = hit_states ? merge_byte(states_q, pwdata, pstrb) : states_q;
  assign wait_en_d = hit_wen ? merge_byte(wait_en_q, pwdata, pstrb) : wait_en_q;
  assign wait_mode_d  = (hit_wctl && pstrb[0]) ?
                        pwdata[area_bus_pkg::WAIT_MODE_POS +: 2] : wait_mode_q;
  assign wait_count_d = (hit_wctl && pstrb[0]) ?
                        pwdata[area_bus_pkg::WAIT_COUNT_POS +: 2] : wait_count_q;

  // Access shaping for the requested area
  assign area          = access_req.area;
  assign area_wen      = wait_en_q[area];
  assign area_long_bit = states_q[area];
  assign eff_mode      = area_wen ? area_bus_pkg::wait_mode_type'(wait_mode_q)
                                  : area_bus_pkg::WAIT_PIN;
  assign eff_waits     = (area_wen && area_long_bit &&
                          (eff_mode == area_bus_pkg::WAIT_PROGRAMMED ||
                           eff_mode == area_bus_pkg::WAIT_PIN_AUTO)) ?
                         wait_count_q : 2'h0;
  assign shape.narrow   = width_q[area];
  assign shape.states   = area_long_bit ? area_bus_pkg::STATES_LONG
                                        : area_bus_pkg::STATES_SHORT;
  assign shape.waits    = eff_waits;
  assign shape.pin_wait = area_long_bit &&
                          (eff_mode == area_bus_pkg::WAIT_PIN ||
                           eff_mode == area_bus_pkg::WAIT_PIN_AUTO);
  assign shape.mode     = eff_mode;
  assign access_shape   = shape;
  assign area_narrow    = width_q;
  assign area_long      = states_q;

  area_access_timer area_access_timer_i
  (
    .clk      (clk),
    .srst     (srst),
    .start    (access_req.valid && !access_busy && !boot_q),
    .shape    (shape),
    .wait_pin (mode_sync_pin_wait_q),
    .busy     (access_busy),
    .done     (access_done)
  );

  // Pin synchronisers
  always_ff @(posedge clk)
  begin
    mode_meta_q          <= mode_pins;
    mode_sync_q          <= mode_meta_q;
    wait_meta_q          <= wait_pin;
    mode_sync_pin_wait_q <= wait_meta_q;
  end

  // Mode capture and boot load
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Pins tracked in reset so the boot load sees the mode
      boot_q <= 1'b1;
      mode_q <= mode_sync_q;
    end
    else
    begin
      boot_q <= 1'b0;
      mode_q <= mode_sync_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      width_q      <= area_bus_pkg::RST_WIDTH_WIDE;
      states_q     <= area_bus_pkg::RST_ACCESS_STATES;
      wait_en_q    <= area_bus_pkg::RST_WAIT_ENABLE;
      wait_mode_q  <= area_bus_pkg::RST_WAIT_MODE;
      wait_count_q <= area_bus_pkg::RST_WAIT_COUNT;
    end
    else if (boot_q)
    begin
      width_q <= boot_narrow ? area_bus_pkg::RST_WIDTH_NARROW
                             : area_bus_pkg::RST_WIDTH_WIDE;
    end
    else if (wr_ok)
    begin
      width_q      <= width_d;
      states_q     <= states_d;
      wait_en_q    <= wait_en_d;
      wait_mode_q  <= wait_mode_d;
      wait_count_q <= wait_count_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : prdata_q;
      pslverr_q <= psel && !penable && (!mapped || (pwrite && hit_mode));
    end
  end

endmodule // area_bus_config

/* area_bus_pkg.sv */
// Purpose: Constants and types for the area bus configuration block
// Assumes: APB register bus with 32-bit data, one word per register
// Notes:   Offsets are register indices; byte address is four times the index
package area_bus_pkg;

  localparam int unsigned NUM_AREAS = 8;

  // Register indices and byte addresses
  localparam logic [7:0]  IDX_BUS_WIDTH     = 8'hec;
  localparam logic [7:0]  IDX_ACCESS_STATES = 8'hed;
  localparam logic [7:0]  IDX_WAIT_CONTROL  = 8'hee;
  localparam logic [7:0]  IDX_WAIT_ENABLE   = 8'hef;
  localparam logic [7:0]  IDX_MODE_REPORT   = 8'hf1;
  localparam logic [11:0] ADDR_BUS_WIDTH     = {2'h0, IDX_BUS_WIDTH, 2'h0};
  localparam logic [11:0] ADDR_ACCESS_STATES = {2'h0, IDX_ACCESS_STATES, 2'h0};
  localparam logic [11:0] ADDR_WAIT_CONTROL  = {2'h0, IDX_WAIT_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_WAIT_ENABLE   = {2'h0, IDX_WAIT_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_MODE_REPORT   = {2'h0, IDX_MODE_REPORT, 2'h0};

  // Reset values
  localparam logic [7:0] RST_WIDTH_NARROW  = 8'hff;
  localparam logic [7:0] RST_WIDTH_WIDE    = 8'h00;
  localparam logic [7:0] RST_ACCESS_STATES = 8'hff;
  localparam logic [7:0] RST_WAIT_ENABLE   = 8'hff;
  localparam logic [1:0] RST_WAIT_MODE     = 2'h0;
  localparam logic [1:0] RST_WAIT_COUNT    = 2'h3;

  // Wait control fields and fixed bits
  localparam int unsigned WAIT_MODE_POS  = 2;
  localparam int unsigned WAIT_COUNT_POS = 0;
  localparam logic [3:0]  WAIT_CTRL_TOP  = 4'hf;
  localparam logic [4:0]  MODE_RPT_TOP   = 5'h18;

  // Access lengths in states
  localparam logic [2:0] STATES_SHORT = 3'h2;
  localparam logic [2:0] STATES_LONG  = 3'h3;

  typedef enum logic [1:0] {
    WAIT_PROGRAMMED = 2'b00,
    WAIT_NONE       = 2'b01,
    WAIT_PIN        = 2'b10,
    WAIT_PIN_AUTO   = 2'b11
  } wait_mode_type;

  typedef enum logic [2:0] {
    MODE_1 = 3'b001,
    MODE_2 = 3'b010,
    MODE_3 = 3'b011,
    MODE_4 = 3'b100
  } boot_mode_type;

  // Per-area access request and resolved shape
  typedef struct packed {
    logic       valid;
    logic [2:0] area;
  } area_req_type;

  typedef struct packed {
    logic          narrow;
    logic [2:0]    states;
    logic [1:0]    waits;
    logic          pin_wait;
    wait_mode_type mode;
  } area_shape_type;

endpackage

/* area_access_timer.sv */
// Purpose: Times one external access: base states plus inserted waits
// Assumes: Shape is stable from start to done
// Notes:   Pin wait stretches the access while wait_pin is high
`timescale 1ns/100ps
module area_access_timer
(
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        start,
  input  wire area_bus_pkg::area_shape_type shape,
  input  wire logic                        wait_pin,
  output logic                             busy,
  output logic                             done
);

  logic [2:0] count_q;
  logic [2:0] count_d;
  logic       busy_q;
  logic       busy_d;
  logic [2:0] total;
  logic       last;
  logic       hold;

  assign total = shape.states + {1'b0, shape.waits};
  assign hold  = shape.pin_wait && wait_pin;
  assign last  = busy_q && (count_q >= total - 3'h1) && !hold;
  assign busy_d  = start ? 1'b1 : (last ? 1'b0 : busy_q);
  assign count_d = start ? 3'h0 : (busy_q && !last ? count_q + 3'h1 : count_q);
  assign busy = busy_q;
  assign done = last;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      busy_q  <= 1'b0;
      count_q <= 3'h0;
    end
    else
    begin
      busy_q  <= busy_d;
      count_q <= count_d;
    end
  end

endmodule // area_access_timer

/* area_bus_config_props.sv */
// Purpose: Port assertions for area_bus_config
// Assumes: One clock, srst synchronous active high
// Notes:   Bound below the module
`timescale 1ns/100ps
module area_bus_config_props
(
  input wire logic                         clk,
  input wire logic                         srst,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  prdata,
  input wire logic                         pslverr,
  input wire area_bus_pkg::area_req_type   access_req,
  input wire area_bus_pkg::area_shape_type access_shape,
  input wire logic                         access_busy,
  input wire logic                         access_done,
  input wire logic [7:0]                   area_narrow,
  input wire logic [7:0]                   area_long
);
  localparam logic [11:0] MR = area_bus_pkg::ADDR_MODE_REPORT;
  wire [2:0] ar = access_req.area;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence mode_rd_s;
    psel && !penable && !pwrite && paddr == MR ##1 penable;
  endsequence
  sequence take_s;
    access_req.valid && !access_busy && !access_shape.pin_wait;
  endsequence
  width_map_a: assert property (access_shape.narrow == area_narrow[ar])
    else $error("width bit misrouted");
  states_map_a: assert property (access_shape.states == (area_long[ar] ? 3'h3 : 3'h2))
    else $error("state count wrong");
  short_nowait_a: assert property (!area_long[ar] |-> access_shape.waits == 2'h0)
    else $error("waits on two-state area");
  done_time_a: assert property (take_s |=> !access_done ##[1:5] access_done)
    else $error("done out of range");
  busy_holds_a: assert property (access_busy && !access_done |=> access_busy)
    else $error("busy dropped early");
  done_end_a: assert property (access_done |-> access_busy ##1 !access_busy)
    else $error("busy not ended by done");
  ro_write_a: assert property (psel && penable && pwrite && paddr == MR |-> pslverr)
    else $error("mode write not refused");
  mode_top_a: assert property (mode_rd_s |-> prdata[7:3] == 5'h18 && !pslverr)
    else $error("mode read wrong");
endmodule // area_bus_config_props

bind area_bus_config area_bus_config_props area_bus_config_props_i (.clk, .srst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pslverr, .access_req, .access_shape, .access_busy,
  .access_done, .area_narrow, .area_long);

/* far_side_model.sv */
// Purpose: Far side peripheral asking for wait states
// Assumes: Waits asked from the first busy cycle
// Notes:   hold_cycles of zero never asks
`timescale 1ns/100ps
module far_side_model
(
  input  wire logic       clk,
  input  wire logic       access_busy,
  input  wire logic [3:0] hold_cycles,
  output logic            wait_pin
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  assign cnt_d = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
  always_ff @(posedge clk)
    cnt_q <= access_busy ? cnt_d : 4'h0;
  assign wait_pin = access_busy && (cnt_q < hold_cycles);
endmodule // far_side_model

/* area_bus_config_test.sv */
// Purpose: Self-checking bench for area_bus_config
// Assumes: APB answer awaited; far side model drives wait_pin
// Notes:   Access length counted from taking edge to done
`timescale 1ns/100ps
module area_bus_config_test;
  logic                         clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]                  paddr = 12'h0;
  logic [31:0]                  pwdata = 32'h0, prdata, r;
  logic [3:0]                   pstrb = 4'hf, hold = 4'h0;
  logic [2:0]                   mode_pins = 3'h1;
  logic                         pready, pslverr, wait_pin, busy, done, e, rdy;
  area_bus_pkg::area_req_type   req = '0;
  area_bus_pkg::area_shape_type shape;
  logic [7:0]                   narrow, along;
  int                           n_fail = 0, comparisons = 0, cyc = 0, n;
  area_bus_config area_bus_config_i (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .mode_pins, .wait_pin, .access_req(req),
    .access_shape(shape), .access_busy(busy), .access_done(done), .area_narrow(narrow),
    .area_long(along));
  far_side_model far_side_model_i (.clk, .access_busy(busy), .hold_cycles(hold), .wait_pin);
  initial
    forever #2 clk = ~clk;
  task automatic finish_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      rdy = pready;
    end while (rdy !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic boot(input logic [2:0] m);
    @(posedge clk);
    mode_pins <= m;
    srst      <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic run(input logic [2:0] a, input logic [1:0] w);
    @(posedge clk);
    req <= '{1'b1, a};
    @(posedge clk);
    req.valid <= 1'b0;
    n = 1;
    @(negedge clk);
    check("waits", shape.waits, w);
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  initial
  begin
    for (int m = 1; m <= 4; m++)
    begin
      boot(m[2:0]);
      apb(0, area_bus_pkg::ADDR_BUS_WIDTH, 0);
      check("width", r, m[0] ? 32'hff : 32'h0);
      apb(0, area_bus_pkg::ADDR_MODE_REPORT, 0);
      check("mode", r, {24'h0, 5'h18, m[2:0]});
    end
    apb(0, area_bus_pkg::ADDR_ACCESS_STATES, 0);
    check("states", r, 32'hff);
    apb(0, area_bus_pkg::ADDR_WAIT_CONTROL, 0);
    check("wctl", r, 32'hf3);
    apb(0, area_bus_pkg::ADDR_WAIT_ENABLE, 0);
    check("wen", r, 32'hff);
    apb(1, area_bus_pkg::ADDR_BUS_WIDTH, 8'h5a);
    pstrb <= 4'he;
    apb(1, area_bus_pkg::ADDR_BUS_WIDTH, 8'h00);
    pstrb <= 4'hf;
    @(negedge clk);
    check("narrow", narrow, 32'h5a);
    for (int a = 0; a < 8; a++)
    begin
      @(posedge clk);
      req.area <= a[2:0];
      @(negedge clk);
      check("area_width", shape.narrow, (32'h5a >> a) & 1);
    end
    apb(1, area_bus_pkg::ADDR_ACCESS_STATES, 8'h0f);
    for (int c = 0; c < 4; c++)
    begin
      apb(1, area_bus_pkg::ADDR_WAIT_CONTROL, 8'(c));
      run(3'h0, 2'(c));
      check("long", n, 3 + c);
      run(3'h4, 2'h0);
      check("short", n, 2);
    end
    for (int m = 0; m < 4; m++)
    begin
      apb(1, area_bus_pkg::ADDR_WAIT_CONTROL, 8'(m * 4 + 2));
      run(3'h0, (m == 0 || m == 3) ? 2'h2 : 2'h0);
      check("wmode", shape.mode, m);
    end
    apb(1, area_bus_pkg::ADDR_WAIT_ENABLE, 8'hfe);
    run(3'h0, 2'h0);
    check("off_mode", shape.mode, 2);
    check("off_len", n, 3);
    apb(1, area_bus_pkg::ADDR_WAIT_ENABLE, 8'hff);
    apb(1, area_bus_pkg::ADDR_WAIT_CONTROL, 8'h08);
    hold <= 4'h6;
    run(3'h0, 2'h0);
    check("pin_stretch", n > 3, 1);
    apb(1, area_bus_pkg::ADDR_MODE_REPORT, 8'h00);
    check("ro_err", e, 1);
    apb(0, 12'h000, 0);
    check("unmap_err", e, 1);
    check("unmap_data", r, 0);
    mode_pins <= 3'h3;
    repeat (4) @(posedge clk);
    apb(0, area_bus_pkg::ADDR_MODE_REPORT, 0);
    check("follow", r, 32'hc3);
    finish_test;
  end
endmodule // area_bus_config_test
